// ---- adcdca_pkg.sv ----
// constants, encodings and register map of the comparator/averager block
package adcdca_pkg;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SEQ_EN = 8'h04;
   localparam logic [7:0] OFF_SEQ_RAW = 8'h08;
   localparam logic [7:0] OFF_SEQ_MASKED = 8'h0C;
   localparam logic [7:0] OFF_CMP_EN = 8'h10;
   localparam logic [7:0] OFF_CMP_STAT = 8'h14;
   localparam logic [7:0] OFF_CMP_RESET = 8'h18;
   localparam logic [2:0] OFF_CMP_CFG_PAGE = 3'h1;
   localparam logic [2:0] OFF_CMP_RANGE_PAGE = 3'h2;
   localparam int CFG_IRQ_LSB = 4;
   localparam int RANGE_UPPER_LSB = 16;
   localparam int RESET_IRQ_LSB = 8;
   localparam logic [2:0] AVG_MAX_CODE = 3'h6;
   localparam logic [2:0] AVG_RST = 3'h0;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [1:0] BAND_LOW = 2'h0;
   localparam logic [1:0] BAND_MID = 2'h1;
   localparam logic [1:0] BAND_TOP = 2'h2;
   localparam logic [1:0] BAND_NONE = 2'h3;
   typedef enum logic [3:0] {
      fault_mode_off = 4'h0,
      fault_low_continuous = 4'h1,
      fault_low_single = 4'h2,
      fault_low_hyst_continuous = 4'h3,
      fault_low_hyst_single = 4'h4,
      fault_middle_continuous = 4'h5,
      fault_middle_single = 4'h6,
      fault_top_continuous = 4'h7,
      fault_top_single = 4'h8,
      fault_top_hyst_continuous = 4'h9,
      fault_top_hyst_single = 4'hA
   } adcdca_mode_e;
   // interrupt modes share the fault encoding
   localparam logic [3:0] irq_low_hyst_continuous = 4'h3;
   localparam logic [3:0] irq_low_hyst_single = 4'h4;
   localparam logic [3:0] irq_top_hyst_continuous = 4'h9;
   localparam logic [3:0] irq_top_hyst_single = 4'hA;
endpackage

// ---- adcdca_eval_if.sv ----
// result band handed from the top to the comparator engines
interface adcdca_eval_if;
   logic valid;
   logic [1:0] band;
   modport src (output valid, output band);
   modport snk (input valid, input band);
endinterface

// ---- adcdca_engine.sv ----
// one comparator decision engine with its own band history
module adcdca_engine (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic hist_clr_i,
   input wire logic [3:0] mode_i,
   adcdca_eval_if.snk ev,
   output logic hit_o
);
   logic [1:0] prev_q;
   logic armed_low_q;
   logic armed_top_q;
   logic is_low;
   logic is_mid;
   logic is_top;
   logic enter;

   always_comb begin
      is_low = ev.band == adcdca_pkg::BAND_LOW;
      is_mid = ev.band == adcdca_pkg::BAND_MID;
      is_top = ev.band == adcdca_pkg::BAND_TOP;
      enter = ev.band != prev_q;
      hit_o = 1'b0;
      if (ev.valid) begin
         unique case (mode_i)
            adcdca_pkg::fault_mode_off: hit_o = 1'b0;
            adcdca_pkg::fault_low_continuous: hit_o = is_low;
            adcdca_pkg::fault_low_single: hit_o = is_low & enter;
            adcdca_pkg::fault_low_hyst_continuous:
               hit_o = is_low & armed_low_q;
            adcdca_pkg::fault_low_hyst_single:
               hit_o = is_low & enter & armed_low_q;
            adcdca_pkg::fault_middle_continuous: hit_o = is_mid;
            adcdca_pkg::fault_middle_single: hit_o = is_mid & enter;
            adcdca_pkg::fault_top_continuous: hit_o = is_top;
            adcdca_pkg::fault_top_single: hit_o = is_top & enter;
            adcdca_pkg::fault_top_hyst_continuous:
               hit_o = is_top & armed_top_q;
            adcdca_pkg::fault_top_hyst_single:
               hit_o = is_top & enter & armed_top_q;
            default: hit_o = 1'b0;
         endcase
      end
   end

   // the first result after reset or history clear counts as an entry
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_q <= adcdca_pkg::BAND_NONE;
      end else if (ce_i) begin
         if (hist_clr_i) begin
            prev_q <= adcdca_pkg::BAND_NONE;
         end else if (ev.valid) begin
            prev_q <= ev.band;
         end
      end
   end

   // arming is consumed by this engine's own hit only
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         armed_low_q <= 1'b0;
         armed_top_q <= 1'b0;
      end else if (ce_i) begin
         if (hist_clr_i) begin
            armed_low_q <= 1'b0;
            armed_top_q <= 1'b0;
         end else if (ev.valid) begin
            armed_low_q <= is_top | (armed_low_q & ~(hit_o & is_low));
            armed_top_q <= is_low | (armed_top_q & ~(hit_o & is_top));
         end
      end
   end

   // a low result whose predecessor was already low is no entry
   sequence s_low_again;
      ce_i && ev.valid && is_low && prev_q == adcdca_pkg::BAND_LOW;
   endsequence

   a_off_silent: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) mode_i == 4'h0 |-> !hit_o)
      else $error("engine hit while mode is off");
   a_cont_every: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      ev.valid && is_top && mode_i == 4'h7 |-> hit_o)
      else $error("continuous mode missed an in-band result");
   a_single_once: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i || hist_clr_i)
      mode_i == 4'h2 ##0 s_low_again |-> !hit_o)
      else $error("single mode fired twice without leaving band");
   a_hyst_armed: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      hit_o && mode_i == 4'h3 |-> armed_low_q && !$past(hist_clr_i))
      else $error("low hysteresis fired without a high result");
endmodule

// ---- adcdca_top.sv ----
// comparator bank, hardware averager and interrupt status with avalon slave
module adcdca_top #(
   parameter int NUM_COMP = 8,
   parameter int NUM_SEQ = 4,
   parameter int DW = 12
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic conv_valid_i,
   input wire logic [DW-1:0] conv_data_i,
   input wire logic [$clog2(NUM_SEQ)-1:0] conv_seq_i,
   input wire logic conv_cmp_en_i,
   input wire logic [$clog2(NUM_COMP)-1:0] conv_cmp_idx_i,
   input wire logic [NUM_SEQ-1:0] seq_done_i,
   output logic fifo_valid_o,
   output logic [DW-1:0] fifo_data_o,
   output logic [$clog2(NUM_SEQ)-1:0] fifo_seq_o,
   output logic [NUM_COMP-1:0] fault_o,
   output logic irq_o
);
   localparam int SW = $clog2(NUM_SEQ);
   localparam int CW = $clog2(NUM_COMP);
   localparam int AW = DW + 6;

   function automatic logic [1:0] band_of(input logic [DW-1:0] v,
                                          input logic [DW-1:0] lo,
                                          input logic [DW-1:0] hi);
      if (v <= lo) begin
         band_of = adcdca_pkg::BAND_LOW;
      end else if (v <= hi) begin
         band_of = adcdca_pkg::BAND_MID;
      end else begin
         band_of = adcdca_pkg::BAND_TOP;
      end
   endfunction

   function automatic logic in_page(input logic [7:0] a,
                                    input logic [2:0] page);
      in_page = a[7:5] == page && a[1:0] == 2'h0 &&
                32'(a[4:2]) < NUM_COMP;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then the access completes
   logic ack_q;
   logic req;
   logic wr_go;
   logic [31:0] rdata_q;
   logic [CW-1:0] widx;

   assign req = avs_read_i | avs_write_i;
   // a frozen cycle must not complete an access that it cannot commit
   assign avs_waitrequest_o = req & ~(ack_q & ce_i);
   assign wr_go = ce_i & avs_write_i & ack_q;
   assign widx = avs_address_i[CW+1:2];
   assign avs_readdata_o = rdata_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
      end else if (ce_i) begin
         ack_q <= req & ~ack_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [2:0] avg_code_q;
   logic [NUM_SEQ-1:0] seq_en_q;
   logic [NUM_SEQ-1:0] cmp_en_q;
   logic [3:0] fmode_q [NUM_COMP];
   logic [3:0] imode_q [NUM_COMP];
   logic [DW-1:0] lo_q [NUM_COMP];
   logic [DW-1:0] hi_q [NUM_COMP];
   logic [3:0] wr_fmode;
   logic [3:0] wr_imode;

   // top bit of the interrupt mode field in the config word
   localparam int CFG_HI = adcdca_pkg::CFG_IRQ_LSB + 3;

   // unknown mode codes fall back to off rather than a random decision
   assign wr_fmode = avs_writedata_i[3:0] > 4'hA ?
                     adcdca_pkg::MODE_RST : avs_writedata_i[3:0];
   assign wr_imode = avs_writedata_i[CFG_HI:adcdca_pkg::CFG_IRQ_LSB] >
                     4'hA ? adcdca_pkg::MODE_RST :
                     avs_writedata_i[CFG_HI:adcdca_pkg::CFG_IRQ_LSB];

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avg_code_q <= adcdca_pkg::AVG_RST;
         seq_en_q <= '0;
         cmp_en_q <= '0;
      end else if (wr_go) begin
         if (avs_address_i == adcdca_pkg::OFF_CTRL &&
             avs_writedata_i[2:0] <= adcdca_pkg::AVG_MAX_CODE) begin
            avg_code_q <= avs_writedata_i[2:0];
         end
         if (avs_address_i == adcdca_pkg::OFF_SEQ_EN) begin
            seq_en_q <= avs_writedata_i[NUM_SEQ-1:0];
         end
         if (avs_address_i == adcdca_pkg::OFF_CMP_EN) begin
            cmp_en_q <= avs_writedata_i[NUM_SEQ-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int k = 0; k < NUM_COMP; k++) begin
            fmode_q[k] <= adcdca_pkg::MODE_RST;
            imode_q[k] <= adcdca_pkg::MODE_RST;
            lo_q[k] <= '0;
            hi_q[k] <= '0;
         end
      end else if (wr_go) begin
         if (in_page(avs_address_i, adcdca_pkg::OFF_CMP_CFG_PAGE)) begin
            fmode_q[widx] <= wr_fmode;
            imode_q[widx] <= wr_imode;
         end
         if (in_page(avs_address_i, adcdca_pkg::OFF_CMP_RANGE_PAGE)) begin
            lo_q[widx] <= avs_writedata_i[DW-1:0];
            hi_q[widx] <= avs_writedata_i[adcdca_pkg::RANGE_UPPER_LSB +:
                                          DW];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hardware averager, one factor for every sequencer
   logic [AW-1:0] acc_q;
   logic [5:0] cnt_q;
   logic [AW-1:0] sum;
   logic [5:0] last_cnt;
   logic avg_restart;
   logic avg_valid_q;
   logic [DW-1:0] avg_data_q;
   logic [SW-1:0] avg_seq_q;
   logic avg_cmp_en_q;
   logic [CW-1:0] avg_cmp_q;

   assign sum = acc_q + AW'(conv_data_i);
   assign last_cnt = 6'((7'h01 << avg_code_q) - 7'h01);
   // a new factor discards a partial sum so no mixed average escapes
   assign avg_restart = wr_go && avs_address_i == adcdca_pkg::OFF_CTRL;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_q <= '0;
         cnt_q <= '0;
         avg_valid_q <= 1'b0;
         avg_data_q <= '0;
         avg_seq_q <= '0;
         avg_cmp_en_q <= 1'b0;
         avg_cmp_q <= '0;
      end else if (ce_i) begin
         avg_valid_q <= 1'b0;
         if (avg_restart) begin
            acc_q <= '0;
            cnt_q <= '0;
         end else if (conv_valid_i) begin
            if (cnt_q == last_cnt) begin
               avg_valid_q <= 1'b1;
               avg_data_q <= DW'(sum >> avg_code_q);
               avg_seq_q <= conv_seq_i;
               avg_cmp_en_q <= conv_cmp_en_i;
               avg_cmp_q <= conv_cmp_idx_i;
               acc_q <= '0;
               cnt_q <= '0;
            end else begin
               acc_q <= sum;
               cnt_q <= cnt_q + 6'h01;
            end
         end
      end
   end

   assign fifo_valid_o = avg_valid_q;
   assign fifo_data_o = avg_data_q;
   assign fifo_seq_o = avg_seq_q;

   ////////////////////////////////////////////////////////////////////
   // comparator bank: fault and interrupt engines per comparator
   logic [NUM_COMP-1:0] fhit;
   logic [NUM_COMP-1:0] ihit;
   logic [NUM_COMP-1:0] fclr;
   logic [NUM_COMP-1:0] iclr;
   logic rst_wr;

   assign rst_wr = wr_go && avs_address_i == adcdca_pkg::OFF_CMP_RESET;
   assign fclr = rst_wr ? avs_writedata_i[NUM_COMP-1:0] : '0;
   assign iclr = rst_wr ? avs_writedata_i[adcdca_pkg::RESET_IRQ_LSB +:
                                          NUM_COMP] : '0;

   for (genvar k = 0; k < NUM_COMP; k++) begin : g_cmp
      adcdca_eval_if u_ev ();
      assign u_ev.valid = avg_valid_q & avg_cmp_en_q &
                          32'(avg_cmp_q) == k;
      assign u_ev.band = band_of(avg_data_q, lo_q[k], hi_q[k]);
      adcdca_engine u_fault (
         .core_clk_i(core_clk_i),
         .rst_n_i(rst_n_i),
         .ce_i(ce_i),
         .hist_clr_i(fclr[k]),
         .mode_i(fmode_q[k]),
         .ev(u_ev.snk),
         .hit_o(fhit[k])
      );
      adcdca_engine u_irq (
         .core_clk_i(core_clk_i),
         .rst_n_i(rst_n_i),
         .ce_i(ce_i),
         .hist_clr_i(iclr[k]),
         .mode_i(imode_q[k]),
         .ev(u_ev.snk),
         .hit_o(ihit[k])
      );

      // the irq engine may fire while the fault side stays silent
      a_fault_quiet: assert property (@(posedge core_clk_i)
         disable iff (!rst_n_i)
         ce_i && fmode_q[k] == adcdca_pkg::MODE_RST |=> !fault_o[k])
         else $error("fault raised while its mode is off");
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_o <= '0;
      end else if (ce_i) begin
         fault_o <= fhit;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt status; a set in the clearing cycle always survives
   logic [NUM_COMP-1:0] cmp_stat_q;
   logic [NUM_COMP-1:0] cmp_stat_d;
   logic [NUM_SEQ-1:0] cmp_src_q;
   logic [NUM_SEQ-1:0] seq_raw_q;
   logic [NUM_SEQ-1:0] seq_clr;
   logic [NUM_SEQ-1:0] seq_masked;
   logic [NUM_COMP-1:0] cstat_clr;
   logic [NUM_SEQ-1:0] seq_rise;

   assign cstat_clr = wr_go && avs_address_i == adcdca_pkg::OFF_CMP_STAT ?
                      avs_writedata_i[NUM_COMP-1:0] : '0;
   assign cmp_stat_d = (cmp_stat_q & ~cstat_clr) | ihit;
   assign seq_rise = wr_go && avs_address_i == adcdca_pkg::OFF_SEQ_EN ?
                     avs_writedata_i[NUM_SEQ-1:0] & ~seq_en_q : '0;
   assign seq_clr = (wr_go && avs_address_i == adcdca_pkg::OFF_SEQ_RAW ?
                     avs_writedata_i[NUM_SEQ-1:0] : '0) | seq_rise;
   assign seq_masked = seq_raw_q & seq_en_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmp_stat_q <= '0;
         cmp_src_q <= '0;
         seq_raw_q <= '0;
      end else if (ce_i) begin
         cmp_stat_q <= cmp_stat_d;
         seq_raw_q <= (seq_raw_q & ~seq_clr) | seq_done_i;
         if (cmp_stat_d == '0) begin
            cmp_src_q <= '0;
         end else if (|ihit) begin
            cmp_src_q[avg_seq_q] <= 1'b1;
         end
      end
   end

   assign irq_o = |seq_masked | |(cmp_src_q & cmp_en_q);

   ////////////////////////////////////////////////////////////////////
   // read mux, loaded in the wait cycle so data stand at completion
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (ce_i && avs_read_i && !ack_q) begin
         rdata_q <= '0;
         if (avs_address_i == adcdca_pkg::OFF_CTRL) begin
            rdata_q[2:0] <= avg_code_q;
         end else if (avs_address_i == adcdca_pkg::OFF_SEQ_EN) begin
            rdata_q[NUM_SEQ-1:0] <= seq_en_q;
         end else if (avs_address_i == adcdca_pkg::OFF_SEQ_RAW) begin
            rdata_q[NUM_SEQ-1:0] <= seq_raw_q;
         end else if (avs_address_i == adcdca_pkg::OFF_SEQ_MASKED) begin
            rdata_q[NUM_SEQ-1:0] <= seq_masked;
         end else if (avs_address_i == adcdca_pkg::OFF_CMP_EN) begin
            rdata_q[NUM_SEQ-1:0] <= cmp_en_q;
         end else if (avs_address_i == adcdca_pkg::OFF_CMP_STAT) begin
            rdata_q[NUM_COMP-1:0] <= cmp_stat_q;
         end else if (in_page(avs_address_i,
                              adcdca_pkg::OFF_CMP_CFG_PAGE)) begin
            rdata_q[3:0] <= fmode_q[widx];
            rdata_q[CFG_HI:adcdca_pkg::CFG_IRQ_LSB] <= imode_q[widx];
         end else if (in_page(avs_address_i,
                              adcdca_pkg::OFF_CMP_RANGE_PAGE)) begin
            rdata_q[DW-1:0] <= lo_q[widx];
            rdata_q[adcdca_pkg::RANGE_UPPER_LSB +: DW] <= hi_q[widx];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   sequence s_stat_clear;
      wr_go && avs_address_i == 8'h14 && !(|ihit);
   endsequence

   a_clear_exact: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_stat_clear |=>
      cmp_stat_q == ($past(cmp_stat_q) &
                     ~$past(avs_writedata_i[NUM_COMP-1:0])))
      else $error("comparator status clear not exact");
   a_enable_flush: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) |seq_rise && !(|seq_done_i) |=>
      (seq_raw_q & $past(seq_rise)) == '0)
      else $error("enabling left stale sequence status");
   a_irq_or: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      irq_o == ((seq_raw_q & seq_en_q) != '0 ||
                (cmp_src_q & cmp_en_q) != '0))
      else $error("interrupt line disagrees with status");
   a_avg_bypass: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      ce_i && conv_valid_i && avg_code_q == 3'h0 && !avg_restart |=>
      fifo_valid_o && fifo_data_o == $past(conv_data_i))
      else $error("factor zero did not pass the sample");
   a_bus_wait: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      ce_i && req && !ack_q |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");

   // a fifo entry only ever follows an accepted conversion
   a_fifo_origin: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      $past(ce_i) && fifo_valid_o |-> $past(conv_valid_i))
      else $error("fifo entry without a completing sample");

   a_seq_clear: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i)
      ce_i && seq_clr != '0 && seq_done_i == '0 |=>
      (seq_raw_q & $past(seq_clr)) == '0)
      else $error("cleared sequence status still pending");
endmodule

// ---- adcdca_conv_model.sv ----
// converter sampling core model feeding results and sequence-done pulses
module adcdca_conv_model (
   input wire logic clk_i,
   output logic valid_o,
   output logic [11:0] data_o,
   output logic [1:0] seq_o,
   output logic cmp_en_o,
   output logic [2:0] idx_o,
   output logic [3:0] done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      valid_o = 1'h0;
      data_o = 12'h000;
      seq_o = 2'h0;
      cmp_en_o = 1'h0;
      idx_o = 3'h0;
      done_o = 4'h0;
   end
   // qualifiers flip after the pulse so nothing stale can pass for a sample
   task automatic send(input logic [11:0] d, input logic [1:0] s,
                       input logic [2:0] k);
      @(posedge clk_i);
      valid_o <= 1'h1;
      data_o <= d;
      seq_o <= s;
      cmp_en_o <= 1'h1;
      idx_o <= k;
      @(posedge clk_i);
      valid_o <= 1'h0;
      data_o <= ~d;
      seq_o <= ~s;
      cmp_en_o <= 1'h0;
      idx_o <= ~k;
   endtask
   task automatic done(input logic [3:0] m);
      @(posedge clk_i);
      done_o <= m;
      @(posedge clk_i);
      done_o <= 4'h0;
   endtask
endmodule

// ---- adc_digital_comparator_averager_test.sv ----
// self-checking bench for the comparator bank, averager and interrupts
module adc_digital_comparator_averager_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, ce, rd, wr, wreq, cv, cen, fv, irq;
   logic [7:0] addr, flt, fseen;
   logic [31:0] wdat, rdat, rv;
   logic [11:0] cd, fdo, fdat;
   logic [1:0] cs, fsq, fs;
   logic [2:0] ck;
   logic [3:0] done;
   logic [23:0] e;
   int bad_count, checks_done, fcnt, p, k, n, j;
   // entry: history reset and mode write flag, mode, expected hit, result
   localparam logic [23:0] TBL [31] = '{24'h111064, 24'h010065,
      24'h151065, 24'h0510C8, 24'h0500C9, 24'h1710C9, 24'h0700C8,
      24'h100032, 24'h121032, 24'h020032, 24'h02012C, 24'h021032,
      24'h18112C, 24'h08012C, 24'h130032, 24'h03012C, 24'h031032,
      24'h030032, 24'h140032, 24'h04012C, 24'h041032, 24'h040032,
      24'h19012C, 24'h090032, 24'h09112C, 24'h09012C, 24'h1A0032,
      24'h0A112C, 24'h0A012C, 24'h161096, 24'h060096};
   localparam logic [7:0] RA [5] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'hFC};
   adcdca_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .conv_valid_i(cv), .conv_data_i(cd),
      .conv_seq_i(cs), .conv_cmp_en_i(cen), .conv_cmp_idx_i(ck),
      .seq_done_i(done), .fifo_valid_o(fv), .fifo_data_o(fdo),
      .fifo_seq_o(fsq), .fault_o(flt), .irq_o(irq));
   adcdca_conv_model i_conv (.clk_i(clk), .valid_o(cv), .data_o(cd),
      .seq_o(cs), .cmp_en_o(cen), .idx_o(ck), .done_o(done));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   task automatic wrap_up();
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         bad_count++;
         $display("mismatch %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int c;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdat <= d;
      c = 0;
      // waitrequest and read data are both taken at the completing edge
      do begin
         @(posedge clk);
         c++;
      end while (wreq !== 1'h0 && c < 20);
      if (wreq !== 1'h0) begin
         bad_count++;
         wrap_up();
      end
      rv = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
      @(negedge clk);
   endtask
   task automatic ev(input logic [11:0] d, input logic [1:0] s,
                     input logic [2:0] q);
      fseen = 8'h00;
      i_conv.send(d, s, q);
      repeat (3) begin
         #1 fseen = fseen | flt;
         if (fv === 1'h1) begin
            fcnt++;
            fdat = fdo;
            fs = fsq;
         end
         @(posedge clk);
      end
   endtask
   initial begin
      rst_n = 1'h0;
      ce = 1'h1;
      rd = 1'h0;
      wr = 1'h0;
      addr = 8'h00;
      wdat = 32'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      foreach (RA[i]) begin
         acc(1'h0, RA[i], 32'h0);
         chk(rv, 32'h0);
      end
      acc(1'h1, 8'h40, 32'h00C80064);
      acc(1'h1, 8'h48, 32'h00C80064);
      for (p = 0; p < 2; p++) foreach (TBL[i]) begin
         e = TBL[i];
         k = p * 2;
         if (e[20]) begin
            acc(1'h1, 8'h18, (32'h1 << k) << (8 * p));
            acc(1'h1, 8'(8'h20 + 4 * k), 32'(e[19:16]) << (4 * p));
         end
         ev(e[11:0], 2'h0, 3'(k));
         if (p == 0) chk(fseen, 32'(e[12]) << k);
         else begin
            chk(fseen, 32'h0);
            acc(1'h0, 8'h14, 32'h0);
            chk(rv, 32'(e[12]) << k);
            acc(1'h1, 8'h14, 32'h1 << k);
         end
      end
      // sequence changes per sample: one factor serves every sequencer
      for (n = 1; n <= 6; n++) begin
         acc(1'h1, 8'h00, 32'(n));
         fcnt = 0;
         for (j = 0; j < (1 << n); j++) ev(12'(j), 2'(j), 3'h0);
         chk(fcnt, 32'h1);
         chk(fdat, 32'(((1 << n) - 1) / 2));
      end
      acc(1'h1, 8'h00, 32'h0);
      fcnt = 0;
      ev(12'h5A5, 2'h3, 3'h0);
      chk(fcnt, 32'h1);
      chk(fdat, 32'h5A5);
      chk(fs, 32'h3);
      // a frozen block must drop the sample rather than emit an entry
      @(posedge clk) ce <= 1'h0;
      fcnt = 0;
      ev(12'h111, 2'h0, 3'h0);
      ce <= 1'h1;
      chk(fcnt, 32'h0);
      acc(1'h1, 8'h14, 32'hFF);
      i_conv.done(4'h2);
      acc(1'h0, 8'h08, 32'h0);
      chk(rv, 32'h2);
      acc(1'h0, 8'h0C, 32'h0);
      chk(rv, 32'h0);
      chk(irq, 32'h0);
      acc(1'h1, 8'h04, 32'h2);
      acc(1'h0, 8'h08, 32'h0);
      chk(rv, 32'h0);
      i_conv.done(4'h2);
      acc(1'h0, 8'h0C, 32'h0);
      chk(rv, 32'h2);
      chk(irq, 32'h1);
      acc(1'h1, 8'h08, 32'h2);
      chk(irq, 32'h0);
      acc(1'h1, 8'h10, 32'h1);
      acc(1'h1, 8'h20, 32'h10);
      ev(12'h032, 2'h0, 3'h0);
      chk(irq, 32'h1);
      acc(1'h1, 8'h10, 32'h0);
      chk(irq, 32'h0);
      wrap_up();
   end
endmodule
